// >>> pkg/prs_consts.svh
// register offsets, field positions, reset values and tables of the strap logic
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// register offsets on the serial port
`define PRS_A_CAL 13'h00E
`define PRS_A_BAND 13'h010
`define PRS_A_FBN 13'h011
`define PRS_A_DIVOV 13'h012
`define PRS_A_XTUNE 13'h01B
`define PRS_A_OPT 13'h01D

// field positions
`define PRS_CAL_GO_BIT 7
`define PRS_CAL_EN_BIT 2
`define PRS_BAND_EN_BIT 0
`define PRS_XT_PIN_BIT 7
`define PRS_OPT_CRYSTAL_PINS_BIT 0
`define PRS_OPT_DBL_BIT 2

// writable bit masks
`define PRS_CAL_MASK 8'h05
`define PRS_XTUNE_MASK 8'hBF
`define PRS_OPT_MASK 8'h05

// reset values
`define PRS_XTUNE_RST 8'hBF
`define PRS_FBN_RST 8'h00

// crystal capacitance: 13 pF fixed plus code times 0.25 pF
`define PRS_CAP_PIN_CODE 6'h08

// strap codes below this value run the reference doubler
`define PRS_DBL_CODE_LIM 3'h4

// nominal reference per strap code, kHz
`define PRS_REF_KHZ0 17'h02710
`define PRS_REF_KHZ1 17'h02EE0
`define PRS_REF_KHZ2 17'h03200
`define PRS_REF_KHZ3 17'h03E80
`define PRS_REF_KHZ4 17'h04B00
`define PRS_REF_KHZ5 17'h04BF0
`define PRS_REF_KHZ6 17'h04E20
`define PRS_REF_KHZ7 17'h06590

// serial frame: 16 instruction bits then 8 data bits
`define PRS_SPI_INS_LAST 5'h0F
`define PRS_SPI_DATA_FIRST 5'h10
`define PRS_SPI_DATA_LAST 5'h17
`define PRS_SPI_FRAME 5'h18

// preset check point: 622.08 MHz output code and its VCO frequency
`define PRS_Y_622 6'h21
`define PRS_VCO_622_KHZ 22'h38F400

`endif

// >>> pkg/prs_pkg.sv
// types of the strap, reference select and calibration logic
package prs_pkg;

  // calibration sequencer
  typedef enum logic [1:0] {
    PRS_CAL_WAIT = 2'b00,
    PRS_CAL_RUN = 2'b01,
    PRS_CAL_DONE = 2'b10
  } prs_cal_state_type;

  // whole state of the top module
  typedef struct packed {
    logic [1:0] cs_s;
    logic [2:0] sclk_s;
    logic [1:0] sdio_s;
    logic [2:0] a_s0;
    logic [2:0] a_s1;
    logic [5:0] y_s0;
    logic [5:0] y_s1;
    logic [1:0] refdet_s;
    logic [1:0] xtok_s;
    logic [2:0] done_s;
    logic [4:0] bitcnt;
    logic [15:0] shreg;
    logic ins_rd;
    logic [12:0] ins_addr;
    logic [7:0] rdata;
    logic sdio_out;
    logic sdio_oe;
    logic [7:0] cal_reg;
    logic [6:0] band;
    logic [7:0] fbn;
    logic divov;
    logic [7:0] xtune;
    logic [7:0] opt;
    prs_cal_state_type cst;
    logic cal_start;
    logic doubler;
    logic use_crystal_pins;
    logic [5:0] cap;
    logic [16:0] ref_khz;
  } prs_state_type;

  // state of the preset table
  typedef struct packed {
    logic [21:0] vco_khz;
  } prs_rom_state_type;

endpackage

// >>> verilog/prs_preset_rom.sv
// preset table: output-select strap code to nominal VCO frequency in kHz
module prs_preset_rom
  import prs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // lookup
  input wire logic [5:0] i_code,
  output logic [21:0] o_vco_khz
);

  prs_rom_state_type r_q;
  prs_rom_state_type r_d;

  // table lookup, result registered
  always_comb begin
    r_d = r_q;
    case (i_code)
      6'h00: r_d.vco_khz = 22'd3732480;
      6'h01: r_d.vco_khz = 22'd3888000;
      6'h02: r_d.vco_khz = 22'd3840000;
      6'h03: r_d.vco_khz = 22'd3932160;
      6'h04: r_d.vco_khz = 22'd3750000;
      6'h05: r_d.vco_khz = 22'd3733296;
      6'h06: r_d.vco_khz = 22'd3560439;
      6'h07: r_d.vco_khz = 22'd3564000;
      6'h08: r_d.vco_khz = 22'd3732480;
      6'h09: r_d.vco_khz = 22'd3932160;
      6'h0A: r_d.vco_khz = 22'd4000000;
      6'h0B: r_d.vco_khz = 22'd3825000;
      6'h0C: r_d.vco_khz = 22'd3840000;
      6'h0D: r_d.vco_khz = 22'd4000000;
      6'h0E: r_d.vco_khz = 22'd3724000;
      6'h0F: r_d.vco_khz = 22'd3732480;
      6'h10: r_d.vco_khz = 22'd3750000;
      6'h11: r_d.vco_khz = 22'd3825000;
      6'h12: r_d.vco_khz = 22'd3867188;
      6'h13: r_d.vco_khz = 22'd3944531;
      6'h14: r_d.vco_khz = 22'd3999086;
      6'h15: r_d.vco_khz = 22'd4015959;
      6'h16: r_d.vco_khz = 22'd4023878;
      6'h17: r_d.vco_khz = 22'd3554742;
      6'h18: r_d.vco_khz = 22'd3932160;
      6'h19: r_d.vco_khz = 22'd4000000;
      6'h1A: r_d.vco_khz = 22'd3732480;
      6'h1B: r_d.vco_khz = 22'd3840000;
      6'h1C: r_d.vco_khz = 22'd4000000;
      6'h1D: r_d.vco_khz = 22'd3471400;
      6'h1E: r_d.vco_khz = 22'd3718750;
      6'h1F: r_d.vco_khz = 22'd3763200;
      6'h20: r_d.vco_khz = 22'd3984375;
      6'h21: r_d.vco_khz = 22'd3732480;
      6'h22: r_d.vco_khz = 22'd3748229;
      6'h23: r_d.vco_khz = 22'd3750000;
      6'h24: r_d.vco_khz = 22'd3763978;
      6'h25: r_d.vco_khz = 22'd3779927;
      6'h26: r_d.vco_khz = 22'd3840000;
      6'h27: r_d.vco_khz = 22'd3849120;
      6'h28: r_d.vco_khz = 22'd3867188;
      6'h29: r_d.vco_khz = 22'd3944531;
      6'h2A: r_d.vco_khz = 22'd3961105;
      6'h2B: r_d.vco_khz = 22'd3999086;
      6'h2C: r_d.vco_khz = 22'd4014769;
      6'h2D: r_d.vco_khz = 22'd4015959;
      6'h2E: r_d.vco_khz = 22'd4017857;
      6'h2F: r_d.vco_khz = 22'd4025032;
      6'h30: r_d.vco_khz = 22'd4032976;
      6'h31: r_d.vco_khz = 22'd3452846;
      6'h32: r_d.vco_khz = 22'd3467415;
      6'h33: r_d.vco_khz = 22'd3468750;
      6'h34: r_d.vco_khz = 22'd3481996;
      6'h35: r_d.vco_khz = 22'd3521903;
      6'h36: r_d.vco_khz = 22'd3536763;
      6'h37: r_d.vco_khz = 22'd3582686;
      6'h38: r_d.vco_khz = 22'd3593750;
      6'h39: r_d.vco_khz = 22'd3598672;
      6'h3A: r_d.vco_khz = 22'd3740355;
      6'h3B: r_d.vco_khz = 22'd3750000;
      6'h3C: r_d.vco_khz = 22'd3888000;
      6'h3D: r_d.vco_khz = 22'd3897843;
      6'h3E: r_d.vco_khz = 22'd3906250;
      default: r_d.vco_khz = 22'd4028320;
    endcase
  end

  // read data register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_vco_khz = r_q.vco_khz;

endmodule

// >>> verilog/prs_strap_ctrl.sv
// strap decode, reference select, crystal tuning, calibration trigger and 3-wire port
//
// How it works
// - strap pin grounded reads 0, open (pulled up) reads 1.
// - 3-bit reference strap picks one of eight nominal reference frequencies.
// - reference codes 000 to 011 turn the doubler on.
// - option register bit 2 turns the doubler on for either source.
// - 6-bit output strap selects a preset divider set and VCO frequency.
// - presets stay fixed; a different actual reference scales the outputs.
// - serial writes can replace the strapped divider values.
// - VCO calibration starts automatically after power-up and every reset.
// - crystal load is 13 pF plus a 6-bit field of 0.25 pF steps.
// - after reset the programmable crystal part is 2 pF.
// - tuning bit 7 cleared uses the 6-bit field, default 15.75 pF.
// - a clock seen on the reference input selects it and stops the crystal.
// - option bit 0 forces the crystal and ignores the presence detector.
// - calibration waits for a valid reference, then starts at once.
// - reset pin high returns all control logic to defaults.
`include "prs_consts.svh"
module prs_strap_ctrl
  import prs_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // strap pins
  input wire logic [2:0] i_ref_sel,
  input wire logic [5:0] i_out_sel,
  // 3-wire serial port
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_sdio_in,
  output logic o_spi_sdio_out,
  output logic o_spi_sdio_oe,
  // analog status
  input wire logic i_ref_present,
  input wire logic i_crystal_pins_ok,
  input wire logic i_cal_done,
  // reference path control
  output logic [16:0] o_ref_nom_khz,
  output logic o_doubler_en,
  output logic o_use_crystal,
  output logic [5:0] o_crystal_pins_cap_code,
  // divider control
  output logic [5:0] o_preset_code,
  output logic [21:0] o_preset_vco_khz,
  output logic o_div_override,
  output logic [7:0] o_fb_int,
  // VCO band and calibration
  output logic o_band_spi,
  output logic [6:0] o_band,
  output logic o_cal_start,
  output logic o_cal_busy
);

  prs_state_type s_q;
  prs_state_type s_d;
  logic sclk_rise;
  logic sclk_fall;
  logic done_rise;
  logic ref_ok;
  logic force_cal;
  logic wr_en;
  logic [7:0] wr_data;

  // register read mux, unmapped addresses read zero
  function automatic logic [7:0] reg_rd(input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `PRS_A_CAL: v = {s_q.cst != PRS_CAL_DONE, s_q.cal_reg[6:0]};
      `PRS_A_BAND: v = {s_q.band, 1'b0};
      `PRS_A_FBN: v = s_q.fbn;
      `PRS_A_DIVOV: v = {7'h00, s_q.divov};
      `PRS_A_XTUNE: v = s_q.xtune;
      `PRS_A_OPT: v = s_q.opt;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // edges and the active reference, from synchronised copies only
  assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_s[2];
  assign sclk_fall = ~s_q.sclk_s[1] & s_q.sclk_s[2];
  assign done_rise = s_q.done_s[1] & ~s_q.done_s[2];
  assign ref_ok = s_q.use_crystal_pins ? s_q.xtok_s[1] : s_q.refdet_s[1];

  // next state
  always_comb begin
    s_d = s_q;
    wr_en = 1'b0;
    wr_data = 8'h00;
    force_cal = 1'b0;
    // two-stage synchronisers; straps read as driven, open pins pulled to 1
    s_d.cs_s = {s_q.cs_s[0], i_spi_cs_n};
    s_d.sclk_s = {s_q.sclk_s[1:0], i_spi_sclk};
    s_d.sdio_s = {s_q.sdio_s[0], i_spi_sdio_in};
    s_d.a_s0 = i_ref_sel;
    s_d.a_s1 = s_q.a_s0;
    s_d.y_s0 = i_out_sel;
    s_d.y_s1 = s_q.y_s0;
    s_d.refdet_s = {s_q.refdet_s[0], i_ref_present};
    s_d.xtok_s = {s_q.xtok_s[0], i_crystal_pins_ok};
    s_d.done_s = {s_q.done_s[1:0], i_cal_done};

    // serial frame: shift on sclk rise, drive read data on sclk fall
    if (s_q.cs_s[1]) begin
      s_d.bitcnt = 5'h00;
      s_d.sdio_oe = 1'b0;
    end else if (sclk_rise) begin
      s_d.shreg = {s_q.shreg[14:0], s_q.sdio_s[1]};
      // counter saturates so stray rises after the frame write nothing
      if (s_q.bitcnt != `PRS_SPI_FRAME) begin
        s_d.bitcnt = s_q.bitcnt + 5'h01;
      end
      // 16th rise: latch direction, address and the byte to send back
      if (s_q.bitcnt == `PRS_SPI_INS_LAST) begin
        s_d.ins_rd = s_q.shreg[14];
        s_d.ins_addr = {s_q.shreg[11:0], s_q.sdio_s[1]};
        s_d.rdata = reg_rd({s_q.shreg[11:0], s_q.sdio_s[1]});
      end
      // 24th rise of a write frame commits the byte
      if (s_q.bitcnt == `PRS_SPI_DATA_LAST && !s_q.ins_rd) begin
        wr_en = 1'b1;
        wr_data = {s_q.shreg[6:0], s_q.sdio_s[1]};
      end
    end else if (sclk_fall) begin
      if (s_q.ins_rd && s_q.bitcnt >= `PRS_SPI_DATA_FIRST && s_q.bitcnt <= `PRS_SPI_DATA_LAST) begin
        s_d.sdio_oe = 1'b1;
        s_d.sdio_out = s_q.rdata[7];
        s_d.rdata = {s_q.rdata[6:0], 1'b0};
      end else begin
        s_d.sdio_oe = 1'b0;
      end
    end

    // register writes
    if (wr_en) begin
      case (s_q.ins_addr)
        `PRS_A_CAL: begin
          s_d.cal_reg = wr_data & `PRS_CAL_MASK;
          // calibrate bit acts only with the enable bit set in the same register
          force_cal = wr_data[`PRS_CAL_GO_BIT] & wr_data[`PRS_CAL_EN_BIT];
        end
        `PRS_A_BAND: s_d.band = wr_data[7:1];
        `PRS_A_FBN: s_d.fbn = wr_data;
        `PRS_A_DIVOV: s_d.divov = wr_data[0];
        `PRS_A_XTUNE: s_d.xtune = wr_data & `PRS_XTUNE_MASK;
        `PRS_A_OPT: s_d.opt = wr_data & `PRS_OPT_MASK;
        default: s_d.cal_reg = s_q.cal_reg;
      endcase
    end

    // calibration sequencer, starts from wait after every reset
    s_d.cal_start = 1'b0;
    unique case (s_q.cst)
      PRS_CAL_WAIT: begin
        if (ref_ok) begin
          s_d.cst = PRS_CAL_RUN;
          s_d.cal_start = 1'b1;
        end
      end
      PRS_CAL_RUN: begin
        if (done_rise) begin
          s_d.cst = PRS_CAL_DONE;
        end
      end
      PRS_CAL_DONE: s_d.cst = PRS_CAL_DONE;
      default: s_d.cst = PRS_CAL_WAIT;
    endcase
    // forced restart beats any start in the same cycle, start follows from wait
    if (force_cal) begin
      s_d.cst = PRS_CAL_WAIT;
      s_d.cal_start = 1'b0;
    end

    // reference path decode
    s_d.doubler = (s_q.a_s1 < `PRS_DBL_CODE_LIM) | s_q.opt[`PRS_OPT_DBL_BIT];
    s_d.use_crystal_pins = s_q.opt[`PRS_OPT_CRYSTAL_PINS_BIT] | ~s_q.refdet_s[1];
    s_d.cap = s_q.xtune[`PRS_XT_PIN_BIT] ? `PRS_CAP_PIN_CODE : s_q.xtune[5:0];
    case (s_q.a_s1)
      3'h0: s_d.ref_khz = `PRS_REF_KHZ0;
      3'h1: s_d.ref_khz = `PRS_REF_KHZ1;
      3'h2: s_d.ref_khz = `PRS_REF_KHZ2;
      3'h3: s_d.ref_khz = `PRS_REF_KHZ3;
      3'h4: s_d.ref_khz = `PRS_REF_KHZ4;
      3'h5: s_d.ref_khz = `PRS_REF_KHZ5;
      3'h6: s_d.ref_khz = `PRS_REF_KHZ6;
      default: s_d.ref_khz = `PRS_REF_KHZ7;
    endcase
  end

  // state register; reset pin returns everything to defaults
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_q <= '0;
      s_q.cs_s <= 2'h3;
      s_q.xtune <= `PRS_XTUNE_RST;
      s_q.fbn <= `PRS_FBN_RST;
      s_q.use_crystal_pins <= 1'b1;
      s_q.cap <= `PRS_CAP_PIN_CODE;
      s_q.ref_khz <= `PRS_REF_KHZ0;
    end else begin
      s_q <= s_d;
    end
  end

  // preset table; presets never track the actual reference frequency
  prs_preset_rom u_rom (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_code(s_q.y_s1),
    .o_vco_khz(o_preset_vco_khz)
  );

  // outputs from state flops
  assign o_spi_sdio_out = s_q.sdio_out;
  assign o_spi_sdio_oe = s_q.sdio_oe;
  assign o_ref_nom_khz = s_q.ref_khz;
  assign o_doubler_en = s_q.doubler;
  assign o_use_crystal = s_q.use_crystal_pins;
  assign o_crystal_pins_cap_code = s_q.cap;
  assign o_preset_code = s_q.y_s1;
  assign o_div_override = s_q.divov;
  assign o_fb_int = s_q.fbn;
  assign o_band_spi = s_q.cal_reg[`PRS_BAND_EN_BIT];
  assign o_band = s_q.band;
  assign o_cal_start = s_q.cal_start;
  assign o_cal_busy = s_q.cst != PRS_CAL_DONE;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_ref_waiting;
    s_q.cst == PRS_CAL_WAIT && ref_ok && !force_cal;
  endsequence

  sequence s_cal_begins;
    s_q.cal_start && s_q.cst == PRS_CAL_RUN;
  endsequence

  sequence s_rst_left;
    i_rst ##1 !i_rst;
  endsequence

  a_dbl_strap: assert property ((s_q.a_s1 < `PRS_DBL_CODE_LIM) |=> s_q.doubler)
    else $error("doubler off for low strap code");
  a_dbl_reg: assert property (s_q.opt[`PRS_OPT_DBL_BIT] |=> s_q.doubler)
    else $error("doubler off with option bit set");
  a_dbl_or: assert property (!s_q.opt[`PRS_OPT_DBL_BIT] && s_q.a_s1 >= `PRS_DBL_CODE_LIM |=> !s_q.doubler)
    else $error("doubler on without a cause");
  a_cap_pin: assert property (s_q.xtune[`PRS_XT_PIN_BIT] |=> o_crystal_pins_cap_code == `PRS_CAP_PIN_CODE)
    else $error("pin capacitance code wrong");
  a_cap_field: assert property (!s_q.xtune[`PRS_XT_PIN_BIT] |=> o_crystal_pins_cap_code == $past(s_q.xtune[5:0]))
    else $error("tuning field not applied");
  a_ref_auto: assert property (s_q.refdet_s[1] && !s_q.opt[`PRS_OPT_CRYSTAL_PINS_BIT] |=> !o_use_crystal)
    else $error("reference input not preferred");
  a_crystal_pins_force: assert property (s_q.opt[`PRS_OPT_CRYSTAL_PINS_BIT] |=> o_use_crystal)
    else $error("crystal not forced");
  a_cal_hold: assert property (s_q.cst == PRS_CAL_WAIT && !ref_ok |=> !o_cal_start)
    else $error("calibration began without reference");
  a_cal_go: assert property (s_ref_waiting |=> s_cal_begins)
    else $error("calibration did not start");
  a_rst_cal: assert property (disable iff (1'b0) s_rst_left |->
                              s_q.cst == PRS_CAL_WAIT && s_q.xtune == `PRS_XTUNE_RST)
    else $error("reset left state off default");
  a_rom_622: assert property (s_q.y_s1 == `PRS_Y_622 [*2] |=> o_preset_vco_khz == `PRS_VCO_622_KHZ)
    else $error("preset VCO frequency wrong");

  // serial port side checks
  sequence s_fbn_write;
    wr_en && s_q.ins_addr == `PRS_A_FBN;
  endsequence

  sequence s_divov_write;
    wr_en && s_q.ins_addr == `PRS_A_DIVOV;
  endsequence

  a_sdio_idle: assert property (s_q.cs_s[1] |=> !o_spi_sdio_oe)
    else $error("data pin driven while deselected");
  a_fb_write: assert property (s_fbn_write |=> o_fb_int == $past(wr_data))
    else $error("feedback integer write lost");
  a_ovr_write: assert property (s_divov_write |=> o_div_override == $past(wr_data[0]))
    else $error("divider override write lost");

  // calibration sequencer checks
  sequence s_cal_finishing;
    s_q.cst == PRS_CAL_RUN && done_rise && !force_cal;
  endsequence

  a_start_pulse: assert property (o_cal_start |=> !o_cal_start)
    else $error("calibration start longer than one cycle");
  a_cal_end: assert property (s_cal_finishing |=> s_q.cst == PRS_CAL_DONE && !o_cal_busy)
    else $error("calibration did not finish");
  a_force_wait: assert property (force_cal |=> s_q.cst == PRS_CAL_WAIT && !o_cal_start)
    else $error("forced calibration did not restart");

  // strap decode and reset defaults
  a_ref_1944: assert property (s_q.a_s1 == 3'h5 |=> o_ref_nom_khz == `PRS_REF_KHZ5)
    else $error("nominal reference wrong");
  a_rst_outs: assert property (disable iff (1'b0) s_rst_left |->
                               o_crystal_pins_cap_code == `PRS_CAP_PIN_CODE && !o_div_override && o_use_crystal)
    else $error("reset left outputs off default");

endmodule

// >>> dv/prs_strap_ctrl_tb.sv
// self-checking bench of the strap, reference select, crystal tuning and calibration logic
module prs_strap_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // design pins
  logic i_clk, i_rst, i_spi_cs_n, i_spi_sclk, tb_sdio, i_ref_present, i_crystal_pins_ok, i_cal_done;
  logic [2:0] i_ref_sel;
  logic [5:0] i_out_sel;
  logic o_spi_sdio_out, o_spi_sdio_oe, o_doubler_en, o_use_crystal, o_div_override, o_band_spi;
  logic o_cal_start, o_cal_busy;
  logic [16:0] o_ref_nom_khz;
  logic [5:0] o_crystal_pins_cap_code, o_preset_code;
  logic [21:0] o_preset_vco_khz;
  logic [7:0] o_fb_int, rd;
  logic [6:0] o_band;
  wire sdio_wire;
  int miscompares, n_compared, n_starts, cycles;

  // expected nominal references (kHz) and preset points
  logic [16:0] ref_tab [8] = '{17'h02710, 17'h02EE0, 17'h03200, 17'h03E80,
                               17'h04B00, 17'h04BF0, 17'h04E20, 17'h06590};
  logic [5:0] y_tab [3] = '{6'h21, 6'h01, 6'h3F};
  logic [21:0] v_tab [3] = '{22'h38F400, 22'h3B5380, 22'h3D77A0};

  // sdio pin level: device wins while it drives
  assign sdio_wire = o_spi_sdio_oe ? o_spi_sdio_out : tb_sdio;

  prs_strap_ctrl u_prs_strap_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_ref_sel(i_ref_sel), .i_out_sel(i_out_sel),
    .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk), .i_spi_sdio_in(sdio_wire),
    .o_spi_sdio_out(o_spi_sdio_out), .o_spi_sdio_oe(o_spi_sdio_oe),
    .i_ref_present(i_ref_present), .i_crystal_pins_ok(i_crystal_pins_ok), .i_cal_done(i_cal_done),
    .o_ref_nom_khz(o_ref_nom_khz), .o_doubler_en(o_doubler_en), .o_use_crystal(o_use_crystal),
    .o_crystal_pins_cap_code(o_crystal_pins_cap_code), .o_preset_code(o_preset_code),
    .o_preset_vco_khz(o_preset_vco_khz), .o_div_override(o_div_override), .o_fb_int(o_fb_int),
    .o_band_spi(o_band_spi), .o_band(o_band), .o_cal_start(o_cal_start), .o_cal_busy(o_cal_busy)
  );

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // calibration start counter and hang guard
  always @(negedge i_clk) begin
    if (o_cal_start === 1'b1) n_starts++;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic check(input string what, input logic [21:0] exp, input logic [21:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one 24-bit frame, msb first, slow sclk so every edge is seen
  task automatic spi(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {ins, wd};
    rdat = 8'h00;
    i_spi_cs_n = 1'b0;
    for (int i = 0; i < 24; i++) begin
      tb_sdio = frame[23 - i];
      step(3);
      i_spi_sclk = 1'b1;
      step(5);
      i_spi_sclk = 1'b0;
      step(5);
      if (ins[15] && i >= 15 && i < 23) rdat[22 - i] = sdio_wire;
    end
    i_spi_cs_n = 1'b1;
    tb_sdio = ~tb_sdio;
    step(6);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    spi({3'b000, a}, d, rd);
  endtask

  task automatic rdc(input string what, input logic [12:0] a, input logic [7:0] exp);
    spi({3'b100, a}, 8'h00, rd);
    check(what, 22'(exp), 22'(rd));
  endtask

  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    i_rst = 1'b1;
    i_spi_cs_n = 1'b1;
    i_spi_sclk = 1'b0;
    tb_sdio = 1'b0;
    i_ref_sel = 3'h7;
    i_out_sel = 6'h3F;
    i_ref_present = 1'b0;
    i_crystal_pins_ok = 1'b0;
    i_cal_done = 1'b0;
    miscompares = 0;
    n_compared = 0;
    n_starts = 0;
    cycles = 0;
    step(4);
    check("cap in reset", 22'h08, 22'(o_crystal_pins_cap_code));
    check("busy in reset", 22'h1, 22'(o_cal_busy));
    i_rst = 1'b0;
    // no reference yet: calibration must wait
    step(30);
    check("starts no ref", 22'h0, 22'(n_starts));
    check("busy no ref", 22'h1, 22'(o_cal_busy));
    check("crystal_pins fallback", 22'h1, 22'(o_use_crystal));
    i_ref_present = 1'b1;
    step(12);
    check("starts on ref", 22'h1, 22'(n_starts));
    check("ref source", 22'h0, 22'(o_use_crystal));
    i_cal_done = 1'b1;
    step(8);
    check("busy done", 22'h0, 22'(o_cal_busy));
    i_cal_done = 1'b0;
    // reference strap decode and doubler for every code
    for (int c = 0; c < 8; c++) begin
      i_ref_sel = c[2:0];
      step(6);
      check("ref nominal", 22'(ref_tab[c]), 22'(o_ref_nom_khz));
      check("strap doubler", 22'(c < 4), 22'(o_doubler_en));
    end
    // output strap presets
    for (int k = 0; k < 3; k++) begin
      i_out_sel = y_tab[k];
      step(6);
      check("preset code", 22'(y_tab[k]), 22'(o_preset_code));
      check("preset vco", v_tab[k], o_preset_vco_khz);
    end
    // crystal tuning register
    rdc("tune reset", 13'h01B, 8'hBF);
    wr(13'h01B, 8'h3F);
    check("cap field max", 22'h3F, 22'(o_crystal_pins_cap_code));
    wr(13'h01B, 8'h05);
    check("cap field", 22'h05, 22'(o_crystal_pins_cap_code));
    wr(13'h01B, 8'h80);
    check("cap pin ctl", 22'h08, 22'(o_crystal_pins_cap_code));
    // reference options: doubler bit and forced crystal
    i_ref_sel = 3'h7;
    wr(13'h01D, 8'h04);
    check("reg doubler", 22'h1, 22'(o_doubler_en));
    wr(13'h01D, 8'h01);
    check("doubler off", 22'h0, 22'(o_doubler_en));
    check("forced crystal_pins", 22'h1, 22'(o_use_crystal));
    rdc("opt readback", 13'h01D, 8'h01);
    wr(13'h01D, 8'h00);
    check("ref again", 22'h0, 22'(o_use_crystal));
    // forced calibration: go bit alone does nothing
    wr(13'h00E, 8'h80);
    check("go alone", 22'h1, 22'(n_starts));
    check("idle busy", 22'h0, 22'(o_cal_busy));
    // strap change, then the host recalibrates
    i_out_sel = 6'h21;
    wr(13'h00E, 8'h84);
    check("forced start", 22'h2, 22'(n_starts));
    check("forced busy", 22'h1, 22'(o_cal_busy));
    rdc("busy readback", 13'h00E, 8'h84);
    check("sdio released", 22'h0, 22'(o_spi_sdio_oe));
    check("preset after strap", v_tab[0], o_preset_vco_khz);
    i_cal_done = 1'b1;
    step(8);
    check("forced done", 22'h0, 22'(o_cal_busy));
    i_cal_done = 1'b0;
    // band set by the host, then a forced calibration
    wr(13'h00E, 8'h05);
    wr(13'h010, 8'hA4);
    check("band ctl", 22'h1, 22'(o_band_spi));
    check("band", 22'h52, 22'(o_band));
    rdc("band readback", 13'h010, 8'hA4);
    wr(13'h00E, 8'h85);
    check("band recal", 22'h3, 22'(n_starts));
    i_cal_done = 1'b1;
    step(8);
    rdc("cal readback", 13'h00E, 8'h05);
    i_cal_done = 1'b0;
    // host divider override, then an unmapped read
    wr(13'h011, 8'h5A);
    wr(13'h012, 8'h01);
    check("fb integer", 22'h5A, 22'(o_fb_int));
    check("div override", 22'h1, 22'(o_div_override));
    rdc("fb readback", 13'h011, 8'h5A);
    rdc("unmapped", 13'h055, 8'h00);
    // reset in mid-run returns defaults and recalibrates
    i_rst = 1'b1;
    step(2);
    check("rst cap", 22'h08, 22'(o_crystal_pins_cap_code));
    check("rst override", 22'h0, 22'(o_div_override));
    check("rst fb", 22'h0, 22'(o_fb_int));
    check("rst busy", 22'h1, 22'(o_cal_busy));
    check("rst band ctl", 22'h0, 22'(o_band_spi));
    i_rst = 1'b0;
    step(12);
    check("start after rst", 22'h4, 22'(n_starts));
    finish_test();
  end
endmodule
